// file: include/dcf_consts.svh
`ifndef DCF_CONSTS_SVH
`define DCF_CONSTS_SVH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define DCF_DATA_W 36
`define DCF_DEPTH 64
`define DCF_PTR_W 7
`define DCF_OFS_W 5
`define DCF_BYTE_W 9
`define DCF_WORD_W 18
`define DCF_BUF_DEPTH 32

// ----------------------------------------
// Pointer and flag values
// ----------------------------------------
`define DCF_PTR_ZERO 7'h00
`define DCF_PTR_ONE 7'h01
`define DCF_FULL_COUNT 7'h40
`define DCF_DATA_ZERO 36'h0_0000_0000

// ----------------------------------------
// Almost-flag offsets, indexed by threshold selects
// ----------------------------------------
`define DCF_OFS_SEL_11 5'h10
`define DCF_OFS_SEL_10 5'h0c
`define DCF_OFS_SEL_01 5'h08
`define DCF_OFS_SEL_00 5'h04

// ----------------------------------------
// Timing counts in port clock edges or clk cycles
// ----------------------------------------
`define DCF_FULL_ARM_EDGES 2'h2
`define DCF_STRAP_WAIT 2'h3

// ----------------------------------------
// Pieces remaining after the first of a long word
// ----------------------------------------
`define DCF_LEFT_LONG 2'h0
`define DCF_LEFT_WORD 2'h1
`define DCF_LEFT_BYTE 2'h3

`endif

// file: include/dcf_pkg.sv
`include "dcf_consts.svh"

package dcf_pkg;

  typedef struct packed {
    logic select_n;
    logic dir;
    logic strobe;
    logic mailbox_sel;
  } dcf_a_ctl_t;

  typedef struct packed {
    logic select_n;
    logic dir;
    logic strobe;
    logic bsize_sel_hi;
    logic bsize_sel_lo;
  } dcf_b_ctl_t;

  typedef struct packed {
    logic clock;
    dcf_a_ctl_t ctl;
    logic [`DCF_DATA_W-1:0] data;
  } dcf_a_pins_t;

  typedef struct packed {
    logic clock;
    dcf_b_ctl_t ctl;
    logic [`DCF_DATA_W-1:0] data;
  } dcf_b_pins_t;

  typedef enum logic [2:0] {
    DCF_SZ_LONG = 3'b001,
    DCF_SZ_WORD = 3'b010,
    DCF_SZ_BYTE = 3'b100
  } dcf_size_t;

endpackage

// file: logic/dcf_store.sv
`timescale 1ns/10ps

module dcf_store #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);

  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
      $error("dcf_store: DEPTH must be a power of two of at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wr_idx_reg;
  logic [AW:0] rd_idx_reg;
  logic do_wr;
  logic do_rd;

  // Extra index bit tells full from empty
  assign wr_ready = (wr_idx_reg[AW-1:0] != rd_idx_reg[AW-1:0]) ||
                    (wr_idx_reg[AW] == rd_idx_reg[AW]);
  assign rd_valid = (wr_idx_reg != rd_idx_reg);
  assign do_wr = wr_valid & wr_ready;
  assign do_rd = rd_ready & rd_valid;
  assign rd_data = mem_reg[rd_idx_reg[AW-1:0]];

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem_reg[wr_idx_reg[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_idx_reg <= '0;
    end else if (do_wr) begin
      wr_idx_reg <= wr_idx_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_idx_reg <= '0;
    end else if (do_rd) begin
      rd_idx_reg <= rd_idx_reg + 1'b1;
    end
  end

endmodule // dcf_store

// file: logic/dcf_core.sv
`timescale 1ns/10ps
`include "dcf_consts.svh"

// Function
// [R01] Port A select, write, strobe, no mailbox, not full: store word in FIFO.
// [R02] Port B select, read, strobe, not empty, size not mailbox: read FIFO.
// [R03] Reset clears pointers, forces flags; full rises after two A edges; offset loads.
// [R04] Mailbox write drives its flag low; writes ignored while flag low.
// [R05] FIFO reads while empty flag low are ignored, nothing changes.
// [R06] In byte or word size, empty drops after last piece of last word.
// [R07] Read pointer advances once per long word moved to output register.
// [R08] Empty flag compares pointers: empty, empty plus one, empty plus two.
// [R09] Written word readable three B cycles later; empty rises at second edge.
// [R10] A B edge too close to a write defers sync to next edge.
// [R11] FIFO writes while full flag low are ignored.
// [R12] Write pointer advances once per long word written.
// [R13] Full flag compares pointers: full, full minus one, full minus two.
// [R14] Freed slot writable three A cycles later; full rises at second edge.
// [R15] An A edge too close to a read defers sync to next edge.
// [R16] Almost-empty compares pointers against flag offset threshold.
// [R17] One offset, loaded at reset, serves both almost flags.
// [R18] Flags follow fill count: 0, 1..X, 64-X..63, 64 levels.
// [R19] Port A mailbox read drives mailbox two, sets its flag high.
// [R20] Port B mailbox size reads mailbox one or writes mailbox two.
// [R21] Seven-bit pointers, top bit wraps, tell full from empty.

module dcf_core (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic port_a_clock,
  input wire dcf_pkg::dcf_a_ctl_t port_a_ctl,
  input wire logic [`DCF_DATA_W-1:0] port_a_data_in,
  output logic [`DCF_DATA_W-1:0] port_a_data_out,
  output logic port_a_data_oe_n,
  input wire logic port_b_clock,
  input wire dcf_pkg::dcf_b_ctl_t port_b_ctl,
  input wire logic [`DCF_DATA_W-1:0] port_b_data_in,
  output logic [`DCF_DATA_W-1:0] port_b_data_out,
  output logic port_b_data_oe_n,
  input wire logic threshold_sel_lo,
  input wire logic threshold_sel_hi,
  output logic full_flag_n,
  output logic almost_full_n,
  output logic empty_flag_n,
  output logic almost_empty_n,
  output logic mail1_full_n,
  output logic mail2_full_n
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [`DCF_OFS_W-1:0] ofs_decode(input logic hi, input logic lo);
    case ({hi, lo})
      2'b11: ofs_decode = `DCF_OFS_SEL_11;
      2'b10: ofs_decode = `DCF_OFS_SEL_10;
      2'b01: ofs_decode = `DCF_OFS_SEL_01;
      default: ofs_decode = `DCF_OFS_SEL_00;
    endcase
  endfunction

  function automatic dcf_pkg::dcf_size_t size_decode(input logic hi, input logic lo);
    case ({hi, lo})
      2'b01: size_decode = dcf_pkg::DCF_SZ_WORD;
      2'b10: size_decode = dcf_pkg::DCF_SZ_BYTE;
      default: size_decode = dcf_pkg::DCF_SZ_LONG;
    endcase
  endfunction

  function automatic logic [1:0] pieces_left(input dcf_pkg::dcf_size_t sz);
    case (sz)
      dcf_pkg::DCF_SZ_BYTE: pieces_left = `DCF_LEFT_BYTE;
      dcf_pkg::DCF_SZ_WORD: pieces_left = `DCF_LEFT_WORD;
      default: pieces_left = `DCF_LEFT_LONG;
    endcase
  endfunction

  // Pieces land in the low lanes; unused lanes read zero
  function automatic logic [`DCF_DATA_W-1:0] piece_sel(
    input logic [`DCF_DATA_W-1:0] w,
    input dcf_pkg::dcf_size_t sz,
    input logic [1:0] idx
  );
    case (sz)
      dcf_pkg::DCF_SZ_BYTE:
        piece_sel = {27'h000_0000, w[idx * `DCF_BYTE_W +: `DCF_BYTE_W]};
      dcf_pkg::DCF_SZ_WORD:
        piece_sel = {18'h0_0000, w[idx[0] * `DCF_WORD_W +: `DCF_WORD_W]};
      default:
        piece_sel = w;
    endcase
  endfunction

  // ----------------------------------------
  // Pin synchronisers and port clock edges
  // ----------------------------------------
  // Port clocks are sampled, so they must run well below clk
  dcf_pkg::dcf_a_pins_t a_s1_reg;
  dcf_pkg::dcf_a_pins_t a_s2_reg;
  dcf_pkg::dcf_b_pins_t b_s1_reg;
  dcf_pkg::dcf_b_pins_t b_s2_reg;
  logic a_clk_d_reg;
  logic b_clk_d_reg;
  logic [1:0] thr_s1_reg;
  logic [1:0] thr_s2_reg;
  logic a_edge;
  logic b_edge;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      a_s1_reg <= '0;
      a_s2_reg <= '0;
      a_clk_d_reg <= 1'b0;
    end else begin
      a_s1_reg <= {port_a_clock, port_a_ctl, port_a_data_in};
      a_s2_reg <= a_s1_reg;
      a_clk_d_reg <= a_s2_reg.clock;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      b_s1_reg <= '0;
      b_s2_reg <= '0;
      b_clk_d_reg <= 1'b0;
    end else begin
      b_s1_reg <= {port_b_clock, port_b_ctl, port_b_data_in};
      b_s2_reg <= b_s1_reg;
      b_clk_d_reg <= b_s2_reg.clock;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      thr_s1_reg <= 2'h0;
      thr_s2_reg <= 2'h0;
    end else begin
      thr_s1_reg <= {threshold_sel_hi, threshold_sel_lo};
      thr_s2_reg <= thr_s1_reg;
    end
  end

  assign a_edge = a_s2_reg.clock & ~a_clk_d_reg;
  assign b_edge = b_s2_reg.clock & ~b_clk_d_reg;

  // ----------------------------------------
  // Port decode
  // ----------------------------------------
  logic a_act;
  logic b_act;
  logic b_mail_size;
  logic a_fifo_try;
  logic a_fifo_wr;
  logic a_mail1_wr;
  logic a_mail2_rd;
  logic b_mail2_wr;
  logic b_mail1_rd;
  logic b_fifo_rd;
  logic b_cont;
  logic b_pop_try;
  logic b_pop;
  logic full_now;
  logic ff_armed;
  logic store_wr_ready;
  logic store_rd_valid;
  logic [`DCF_DATA_W-1:0] store_rd_data;
  logic [`DCF_PTR_W-1:0] count_a;
  logic [`DCF_PTR_W-1:0] count_b;
  logic mail1_full_n_reg;
  logic mail2_full_n_reg;
  logic [1:0] piece_left_reg;
  logic [1:0] piece_idx_reg;
  dcf_pkg::dcf_size_t size_cur_reg;
  dcf_pkg::dcf_size_t b_size;

  assign a_act = a_edge & ~a_s2_reg.ctl.select_n & a_s2_reg.ctl.strobe;
  assign b_act = b_edge & ~b_s2_reg.ctl.select_n & b_s2_reg.ctl.strobe;
  assign b_mail_size = b_s2_reg.ctl.bsize_sel_hi & b_s2_reg.ctl.bsize_sel_lo;
  assign b_size = size_decode(b_s2_reg.ctl.bsize_sel_hi, b_s2_reg.ctl.bsize_sel_lo);

  assign a_fifo_try = a_act & a_s2_reg.ctl.dir & ~a_s2_reg.ctl.mailbox_sel &
                      ff_armed & ~full_now; // [R01] [R11]
  assign a_fifo_wr = a_fifo_try & store_wr_ready;
  assign a_mail1_wr = a_act & a_s2_reg.ctl.dir & a_s2_reg.ctl.mailbox_sel &
                      mail1_full_n_reg; // [R04]
  assign a_mail2_rd = a_act & ~a_s2_reg.ctl.dir & a_s2_reg.ctl.mailbox_sel; // [R19]
  assign b_mail2_wr = b_act & b_s2_reg.ctl.dir & b_mail_size & mail2_full_n_reg; // [R20] [R04]
  assign b_mail1_rd = b_act & ~b_s2_reg.ctl.dir & b_mail_size; // [R20]
  assign b_fifo_rd = b_act & ~b_s2_reg.ctl.dir & ~b_mail_size; // [R02]

  // Same size with pieces pending continues; a new size reloads and drops the rest
  assign b_cont = b_fifo_rd & (b_size == size_cur_reg) & (piece_left_reg != 2'h0); // [R06]
  assign b_pop_try = b_fifo_rd & ~b_cont & (count_b != `DCF_PTR_ZERO); // [R05]
  assign b_pop = b_pop_try & store_rd_valid;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  dcf_store #(
    .WIDTH(`DCF_DATA_W),
    .DEPTH(`DCF_DEPTH)
  ) u_store (
    .clk(clk),
    .arst_n(arst_n),
    .wr_valid(a_fifo_try),
    .wr_ready(store_wr_ready),
    .wr_data(a_s2_reg.data),
    .rd_valid(store_rd_valid),
    .rd_ready(b_pop_try),
    .rd_data(store_rd_data)
  );

  // ----------------------------------------
  // Pointers and cross-port copies
  // ----------------------------------------
  logic [`DCF_PTR_W-1:0] wr_ptr_reg;
  logic [`DCF_PTR_W-1:0] rd_ptr_reg;
  logic [`DCF_PTR_W-1:0] wr_b1_reg;
  logic [`DCF_PTR_W-1:0] wr_b2_reg;
  logic [`DCF_PTR_W-1:0] rd_a1_reg;
  logic [`DCF_PTR_W-1:0] rd_a2_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg <= `DCF_PTR_ZERO; // [R03]
    end else if (a_fifo_wr) begin
      wr_ptr_reg <= wr_ptr_reg + `DCF_PTR_ONE; // [R12] [R21]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_ptr_reg <= `DCF_PTR_ZERO; // [R03]
    end else if (b_pop) begin
      rd_ptr_reg <= rd_ptr_reg + `DCF_PTR_ONE; // [R07] [R21]
    end
  end

  // A write in the same clk as a B edge is caught only by the next edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_b1_reg <= `DCF_PTR_ZERO;
      wr_b2_reg <= `DCF_PTR_ZERO;
    end else if (b_edge) begin
      wr_b1_reg <= wr_ptr_reg; // [R10]
      wr_b2_reg <= wr_b1_reg; // [R09]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_a1_reg <= `DCF_PTR_ZERO;
      rd_a2_reg <= `DCF_PTR_ZERO;
    end else if (a_edge) begin
      rd_a1_reg <= rd_ptr_reg; // [R15]
      rd_a2_reg <= rd_a1_reg; // [R14]
    end
  end

  assign count_a = wr_ptr_reg - rd_a2_reg; // [R13]
  assign count_b = wr_b2_reg - rd_ptr_reg; // [R08]
  assign full_now = (count_a == `DCF_FULL_COUNT); // [R13]

  // ----------------------------------------
  // Reset arming and offset load
  // ----------------------------------------
  logic [1:0] ff_arm_reg;
  logic [1:0] strap_wait_reg;
  logic [`DCF_OFS_W-1:0] ofs_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ff_arm_reg <= 2'h0;
    end else if (a_edge && ff_arm_reg != `DCF_FULL_ARM_EDGES) begin
      ff_arm_reg <= ff_arm_reg + 2'h1; // [R03]
    end
  end

  assign ff_armed = (ff_arm_reg == `DCF_FULL_ARM_EDGES);

  // Selects are read only once the synchroniser holds post-reset levels
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_wait_reg <= 2'h0;
    end else if (strap_wait_reg != `DCF_STRAP_WAIT) begin
      strap_wait_reg <= strap_wait_reg + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ofs_reg <= `DCF_OFS_SEL_00;
    end else if (strap_wait_reg == `DCF_STRAP_WAIT - 2'h1) begin
      ofs_reg <= ofs_decode(thr_s2_reg[1], thr_s2_reg[0]); // [R03] [R17]
    end
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      full_flag_n <= 1'b0; // [R03]
      almost_full_n <= 1'b1;
    end else begin
      full_flag_n <= ff_armed & ~full_now; // [R18] [R14]
      almost_full_n <= (count_a < (`DCF_FULL_COUNT - {2'b00, ofs_reg})); // [R18] [R17]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      empty_flag_n <= 1'b0; // [R03]
      almost_empty_n <= 1'b0;
    end else begin
      empty_flag_n <= (count_b != `DCF_PTR_ZERO) | (piece_left_reg != 2'h0); // [R06] [R18]
      almost_empty_n <= (count_b > {2'b00, ofs_reg}); // [R16] [R18]
    end
  end

  // ----------------------------------------
  // Port B output register and bus sizing
  // ----------------------------------------
  logic [`DCF_DATA_W-1:0] hold_reg;
  logic [`DCF_DATA_W-1:0] fifo_out_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_reg <= `DCF_DATA_ZERO;
      fifo_out_reg <= `DCF_DATA_ZERO;
      piece_left_reg <= 2'h0;
      piece_idx_reg <= 2'h0;
      size_cur_reg <= dcf_pkg::DCF_SZ_LONG;
    end else if (b_pop) begin
      hold_reg <= store_rd_data;
      fifo_out_reg <= piece_sel(store_rd_data, b_size, 2'h0); // [R02]
      piece_left_reg <= pieces_left(b_size);
      piece_idx_reg <= 2'h0;
      size_cur_reg <= b_size;
    end else if (b_cont) begin
      fifo_out_reg <= piece_sel(hold_reg, size_cur_reg, piece_idx_reg + 2'h1); // [R06]
      piece_left_reg <= piece_left_reg - 2'h1;
      piece_idx_reg <= piece_idx_reg + 2'h1;
    end
  end

  // ----------------------------------------
  // Mailboxes
  // ----------------------------------------
  logic [`DCF_DATA_W-1:0] mail1_reg;
  logic [`DCF_DATA_W-1:0] mail2_reg;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mail1_reg <= `DCF_DATA_ZERO;
      mail1_full_n_reg <= 1'b1;
    end else if (a_mail1_wr) begin
      mail1_reg <= a_s2_reg.data;
      mail1_full_n_reg <= 1'b0; // [R04]
    end else if (b_mail1_rd) begin
      mail1_full_n_reg <= 1'b1; // [R20]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mail2_reg <= `DCF_DATA_ZERO;
      mail2_full_n_reg <= 1'b1;
    end else if (b_mail2_wr) begin
      mail2_reg <= b_s2_reg.data;
      mail2_full_n_reg <= 1'b0; // [R04] [R20]
    end else if (a_mail2_rd) begin
      mail2_full_n_reg <= 1'b1; // [R19]
    end
  end

  assign mail1_full_n = mail1_full_n_reg;
  assign mail2_full_n = mail2_full_n_reg;

  // ----------------------------------------
  // Data pins
  // ----------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      port_a_data_out <= `DCF_DATA_ZERO;
      port_b_data_out <= `DCF_DATA_ZERO;
    end else begin
      port_a_data_out <= mail2_reg; // [R19]
      port_b_data_out <= b_mail_size ? mail1_reg : fifo_out_reg; // [R20]
    end
  end

  assign port_a_data_oe_n = a_s2_reg.ctl.select_n | a_s2_reg.ctl.dir;
  assign port_b_data_oe_n = b_s2_reg.ctl.select_n | b_s2_reg.ctl.dir;

endmodule // dcf_core

// file: dv/dcf_port_host.sv
`timescale 1ns/10ps

module dcf_port_host #(
  parameter int CW = 4,
  parameter int HALF = 4
) (
  input wire logic clk,
  input wire logic [CW-1:0] ctl_next,
  input wire logic [35:0] data_next,
  output logic pclk,
  output logic [CW-1:0] ctl,
  output logic [35:0] data,
  output logic fell
);
  logic [3:0] cnt_reg;

  initial begin
    cnt_reg = 4'h0;
    pclk = 1'b0;
    ctl = {1'b1, {(CW - 1){1'b0}}};
    data = 36'h0_0000_0000;
    fell = 1'b0;
  end

  // ----------------------------------------
  // Free-running port clock, requests change on its falling edge
  // ----------------------------------------
  always @(posedge clk) begin
    fell <= 1'b0;
    if (cnt_reg == HALF - 1) begin
      cnt_reg <= 4'h0;
      pclk <= ~pclk;
      fell <= pclk;
      if (pclk) begin
        // Held a whole period so the rising edge sees it settled
        ctl <= ctl_next;
        data <= ctl_next[CW-2] ? data_next : ~data;
      end
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
      // Released bus must not look like stale data
      if (!ctl[CW-2]) begin
        data <= ~data;
      end
    end
  end
endmodule // dcf_port_host

// file: dv/dcf_core_sva.sv
`timescale 1ns/10ps
`include "dcf_consts.svh"

module dcf_core_sva (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic port_a_clock,
  input wire dcf_pkg::dcf_a_ctl_t port_a_ctl,
  input wire logic port_b_clock,
  input wire dcf_pkg::dcf_b_ctl_t port_b_ctl,
  input wire logic [`DCF_DATA_W-1:0] port_a_data_out,
  input wire logic [`DCF_DATA_W-1:0] port_b_data_out,
  input wire logic full_flag_n,
  input wire logic almost_full_n,
  input wire logic empty_flag_n,
  input wire logic almost_empty_n,
  input wire logic mail1_full_n,
  input wire logic mail2_full_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  // ----------------------------------------
  // Port A edges seen since reset release
  // ----------------------------------------
  // Counted at the pin, so it runs ahead of the design's synchroniser
  logic a_prev_reg;
  logic [1:0] a_rise_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      a_prev_reg <= 1'b0;
      a_rise_reg <= 2'h0;
    end else begin
      a_prev_reg <= port_a_clock;
      if (port_a_clock && !a_prev_reg && a_rise_reg != 2'h3) begin
        a_rise_reg <= a_rise_reg + 2'h1;
      end
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  chk_reset_flag_levels: assert property ($rose(arst_n) |-> !full_flag_n && !empty_flag_n
    && !almost_empty_n && almost_full_n && mail1_full_n && mail2_full_n)
    else $error("flags wrong right after reset");
  chk_full_arm_early: assert property (a_rise_reg < 2'h2 |-> !full_flag_n)
    else $error("full flag released too early");
  chk_full_arm_late: assert property (a_rise_reg == 2'h3 && $past(a_rise_reg) == 2'h2
    |-> full_flag_n)
    else $error("full flag not released after two edges");
  chk_empty_ae_level: assert property (!empty_flag_n |-> !almost_empty_n)
    else $error("almost empty high while empty");
  chk_full_af_level: assert property ($fell(full_flag_n) && $past(arst_n)
    |-> !almost_full_n)
    else $error("almost full high while full");
  chk_mail1_write_flag: assert property ($rose(port_a_clock) && port_a_ctl == 4'h7
    && mail1_full_n |-> ##[1:6] !mail1_full_n)
    else $error("mail1 write did not set its flag");
  chk_mail2_data_hold: assert property ((!mail2_full_n) [*4] |-> $stable(port_a_data_out))
    else $error("mail2 data changed while flag low");
  chk_mail2_read_clear: assert property ($rose(port_a_clock) && port_a_ctl == 4'h3
    |-> ##[1:6] mail2_full_n)
    else $error("mail2 read did not clear its flag");
  chk_mail1_read_clear: assert property ($rose(port_b_clock) && port_b_ctl == 5'h07
    |-> ##[1:6] mail1_full_n)
    else $error("mail1 read did not clear its flag");
  chk_empty_read_ignored: assert property ($rose(port_b_clock) && !empty_flag_n
    && port_b_ctl[4:2] == 3'b001 && port_b_ctl[1:0] != 2'b11
    |=> $stable(port_b_data_out) [*6])
    else $error("read while empty changed output");
endmodule // dcf_core_sva

bind dcf_core dcf_core_sva dcf_core_sva_i (
  .clk(clk),
  .arst_n(arst_n),
  .port_a_clock(port_a_clock),
  .port_a_ctl(port_a_ctl),
  .port_b_clock(port_b_clock),
  .port_b_ctl(port_b_ctl),
  .port_a_data_out(port_a_data_out),
  .port_b_data_out(port_b_data_out),
  .full_flag_n(full_flag_n),
  .almost_full_n(almost_full_n),
  .empty_flag_n(empty_flag_n),
  .almost_empty_n(almost_empty_n),
  .mail1_full_n(mail1_full_n),
  .mail2_full_n(mail2_full_n)
);

// file: dv/dcf_core_tb.sv
`timescale 1ns/10ps

module dcf_core_tb;
  localparam logic [3:0] A_IDLE = 4'h8;
  localparam logic [3:0] A_WR = 4'h6;
  localparam logic [3:0] A_M1W = 4'h7;
  localparam logic [3:0] A_M2R = 4'h3;
  localparam logic [3:0] A_RD0 = 4'h2;
  localparam logic [4:0] B_IDLE = 5'h10;
  localparam logic [4:0] B_RDL = 5'h04;
  localparam logic [4:0] B_RDW = 5'h05;
  localparam logic [4:0] B_RDB = 5'h06;
  localparam logic [4:0] B_M1R = 5'h07;
  localparam logic [4:0] B_M2W = 5'h0f;
  localparam logic [4:0] B_PARK = 5'h13;
  logic clk, arst_n, ts_lo, ts_hi, a_clk, b_clk, a_fell, b_fell, a_oe_n, b_oe_n;
  logic ff_n, af_n, ef_n, ae_n, m1_n, m2_n;
  logic [3:0] a_next, a_ctl;
  logic [4:0] b_next, b_ctl;
  logic [35:0] a_dnext, b_dnext, a_din, b_din, a_dout, b_dout, d;
  logic [35:0] q[$];
  int err_count, samples_checked, x;

  dcf_port_host #(.CW(4), .HALF(4)) host_a_i (.clk(clk), .ctl_next(a_next),
    .data_next(a_dnext), .pclk(a_clk), .ctl(a_ctl), .data(a_din), .fell(a_fell));
  dcf_port_host #(.CW(5), .HALF(5)) host_b_i (.clk(clk), .ctl_next(b_next),
    .data_next(b_dnext), .pclk(b_clk), .ctl(b_ctl), .data(b_din), .fell(b_fell));
  dcf_core dcf_core_i (.clk(clk), .arst_n(arst_n), .port_a_clock(a_clk), .port_a_ctl(a_ctl),
    .port_a_data_in(a_din), .port_a_data_out(a_dout), .port_a_data_oe_n(a_oe_n),
    .port_b_clock(b_clk), .port_b_ctl(b_ctl), .port_b_data_in(b_din),
    .port_b_data_out(b_dout), .port_b_data_oe_n(b_oe_n), .threshold_sel_lo(ts_lo),
    .threshold_sel_hi(ts_hi), .full_flag_n(ff_n), .almost_full_n(af_n),
    .empty_flag_n(ef_n), .almost_empty_n(ae_n), .mail1_full_n(m1_n), .mail2_full_n(m2_n));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [35:0] flags();
    return {30'h0, m1_n, m2_n, ef_n, ae_n, af_n, ff_n};
  endfunction

  function automatic logic [35:0] lvl(int n, int ofs);
    return {30'h0, 2'b11, n > 0, n > ofs, n < 64 - ofs, n < 64};
  endfunction

  function automatic logic [35:0] rnd();
    logic [63:0] r;
    r = {$urandom(), $urandom()};
    return r[35:0];
  endfunction

  task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("Counts: %0d mismatches in %0d checks", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic wait_fell(input bit port_b);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((port_b ? b_fell : a_fell) !== 1'b1 && n < 100);
    if (n >= 100) begin
      err_count++;
      $display("[FAIL] port clock stalled");
      close_out();
    end
  endtask

  task automatic a_op(input logic [3:0] c, input logic [35:0] v);
    wait_fell(1'b0);
    a_next <= c;
    a_dnext <= v;
    wait_fell(1'b0);
    // Synced controls reach the decode two clk after the pin change
    repeat (2) @(posedge clk);
    check("port a drive", {35'h0, c[3] | c[2]}, {35'h0, a_oe_n});
    a_next <= A_IDLE;
  endtask

  task automatic b_op(input logic [4:0] c, input logic [35:0] v, input logic [4:0] rest);
    wait_fell(1'b1);
    b_next <= c;
    b_dnext <= v;
    wait_fell(1'b1);
    b_next <= rest;
    // Output pin settles two clk past the detected B rise
    repeat (9) @(posedge clk);
    check("port b drive", {35'h0, c[4] | c[3]}, {35'h0, b_oe_n});
  endtask

  // Three edges of each port clock cover the two-stage flag sync
  task automatic settle();
    repeat (3) begin
      wait_fell(1'b0);
      wait_fell(1'b1);
    end
  endtask

  task automatic do_reset(input logic [1:0] sel);
    arst_n <= 1'b0;
    {ts_hi, ts_lo} <= sel;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    q.delete();
    repeat (2) @(posedge clk);
    check("reset flags", 36'h32, flags());
    repeat (3) wait_fell(1'b0);
    check("armed flags", 36'h33, flags());
  endtask

  // ----------------------------------------
  // Clock and sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    arst_n = 1'b0;
    ts_lo = 1'b0;
    ts_hi = 1'b0;
    a_next = A_IDLE;
    b_next = B_IDLE;
    a_dnext = 36'h0;
    b_dnext = 36'h0;
    err_count = 0;
    samples_checked = 0;
    void'($urandom(37));
    for (int s = 0; s < 4; s++) begin
      x = (s == 3) ? 16 : (s == 2) ? 12 : (s == 1) ? 8 : 4;
      do_reset(s[1:0]);
      b_op(B_RDL, 36'h0, B_IDLE);
      check("empty read", 36'h0, b_dout);
      for (int k = 1; k <= 64; k++) begin
        d = rnd();
        a_op(A_WR, d);
        q.push_back(d);
        if (k == x || k == x + 1 || k == 63 - x || k == 64 - x || k == 64) begin
          settle();
          check("fill flags", lvl(k, x), flags());
        end
      end
      a_op(A_WR, rnd());
      b_op(B_RDL, 36'h0, B_IDLE);
      check("first read", q.pop_front(), b_dout);
      settle();
      check("freed flags", lvl(63, x), flags());
      d = rnd();
      a_op(A_WR, d);
      q.push_back(d);
      settle();
      check("refill flags", lvl(64, x), flags());
      while (q.size() > 0) begin
        b_op(B_RDL, 36'h0, B_IDLE);
        check("drain read", q.pop_front(), b_dout);
      end
      settle();
      check("drained flags", lvl(0, x), flags());
      $display("Offset %0d fill test done", x);
    end
    q.push_back(rnd());
    q.push_back(rnd());
    a_op(A_WR, q[0]);
    a_op(A_WR, q[1]);
    settle();
    for (int i = 0; i < 4; i++) begin
      b_op(B_RDB, 36'h0, B_IDLE);
      check("byte piece", {27'h0, q[0][9*i +: 9]}, b_dout);
    end
    for (int i = 0; i < 2; i++) begin
      b_op(B_RDW, 36'h0, B_IDLE);
      check("word piece", {18'h0, q[1][18*i +: 18]}, b_dout);
      settle();
      check("empty after piece", {35'h0, i == 0}, {35'h0, ef_n});
    end
    $display("Bus size test done");
    d = rnd();
    a_op(A_M1W, d);
    a_op(A_M1W, ~d);
    b_op(B_M1R, 36'h0, B_PARK);
    check("mail1 data", d, b_dout);
    settle();
    check("mail1 flag", 36'h1, {35'h0, m1_n});
    d = rnd();
    b_op(B_M2W, d, B_IDLE);
    b_op(B_M2W, ~d, B_IDLE);
    a_op(A_RD0, 36'h0);
    settle();
    check("mail2 held", d, a_dout);
    check("mail2 flag", 36'h0, {35'h0, m2_n});
    a_op(A_M2R, 36'h0);
    settle();
    check("mail2 read", d, a_dout);
    check("mail2 clear", 36'h1, {35'h0, m2_n});
    $display("Mailbox test done");
    close_out();
  end
endmodule // dcf_core_tb
